// ### hw/power_mode_pkg.sv
// power mode controller package: modes, registers, interrupt sources
// assumes a 32-bit axi4-lite master and a 50 mhz aclk
package power_mode_pkg;

  typedef enum logic [2:0] {
    mode_active,
    mode_sleep,
    mode_standby,
    mode_watch,
    mode_subactive,
    mode_settle
  } mode_t;

  // interrupt source indices
  localparam int unsigned SRC_EXT0     = 0;
  localparam int unsigned SRC_EXT1     = 1;
  localparam int unsigned SRC_EXT4     = 2;
  localparam int unsigned SRC_EXT5     = 3;
  localparam int unsigned SRC_KEYSCAN  = 4;
  localparam int unsigned SRC_TIMER_A  = 5;
  localparam int unsigned SRC_TIMER_B  = 6;
  localparam int unsigned SRC_TIMER_C  = 7;
  localparam int unsigned SRC_TIMER_D  = 8;
  localparam int unsigned SRC_TIMER_E  = 9;
  localparam int unsigned SRC_DIRECT   = 10;
  localparam int unsigned SRC_SERIAL1  = 11;
  localparam int unsigned SRC_SERIAL2  = 12;
  localparam int unsigned SRC_ADC      = 13;
  localparam int unsigned NUM_SRC      = 14;

  // validity of each source per mode (bit = source index)
  localparam logic [13:0] VALID_ACTIVE    = 14'h3bff;
  localparam logic [13:0] VALID_SLEEP     = 14'h0023;
  localparam logic [13:0] VALID_STANDBY   = 14'h0003;
  localparam logic [13:0] VALID_WATCH     = 14'h0021;
  localparam logic [13:0] VALID_SUBACTIVE = 14'h0421;

  // register byte offsets
  localparam logic [7:0] ADDR_SYS_CTRL_ONE = 8'h00;
  localparam logic [7:0] ADDR_SYS_CTRL_TWO = 8'h04;
  localparam logic [7:0] ADDR_TIMER_A_MODE = 8'h08;
  localparam logic [7:0] ADDR_INT_ENABLE   = 8'h0c;
  localparam logic [7:0] ADDR_INT_REQUEST  = 8'h10;
  localparam logic [7:0] ADDR_MODE_STATUS  = 8'h14;

  // field positions
  localparam int unsigned STANDBY_SELECT_POS = 7;
  localparam int unsigned LOW_SPEED_ON_POS   = 3;
  localparam int unsigned SETTLE_SEL_LSB     = 4;
  localparam int unsigned DIRECT_XFER_POS    = 0;
  localparam int unsigned TIMEBASE_SEL_POS   = 3;

  // reset values
  localparam logic [7:0]  SYS_CTRL_ONE_RST = 8'h00;
  localparam logic [7:0]  SYS_CTRL_TWO_RST = 8'h00;
  localparam logic [7:0]  TIMER_A_MODE_RST = 8'h00;
  localparam logic [13:0] INT_ENABLE_RST   = 14'h0000;

  // settling wait per select code, in cycles of aclk
  localparam int unsigned SETTLE_BASE_CYCLES = 8;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic clock_stop;
    logic cpu_halt;
    logic cpu_on_subclock;
    logic periph_halt;
    logic timer_a_run;
    logic output_reset;
    logic ports_hiz;
    logic hv_pmos_off;
  } gate_t;

  typedef struct packed {
    logic [7:0]  condition_code_register;
    logic [15:0] addr;
  } stack_t;

endpackage : power_mode_pkg

// ### hw/power_mode_controller.sv
// power mode controller: mode sequencing, wake gating, stack word helpers
// assumes sleep_exec is a one-cycle pulse from the cpu core and that the
// cpu keeps the stack pointer even; software clears request flags by bus
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps

// What this block does
// - sleep with standby bit clear enters sleep
// - standby bit set, timebase clear: standby
// - standby bit set, timebase set: watch
// - watch wake with low speed: subactive
// - sleep keeps clocks, ext zero/one, timer a
// - exception needs mask clear and enable set
// - mode returns before exception handling starts
// - direct transfer: watch, flag, then active
// - invalid interrupts set no flag, no transition
// - timer a runs in active (not during reset or the cycle after) and sleep; in watch and subactive only if timebase selected
// - low power modes reset display, pwm outputs
// - active mode runs cpu on system clock
// - word access forces address bit zero low
// - stacked condition code in both bytes
// - restore condition code from even byte
// - sleep left on enabled ext/timer a interrupt
// - standby wake waits selected settling time
// - watch wake: active after settle or subactive
// - subactive sleep without direct bit: watch
module power_mode_controller
  import power_mode_pkg::*;
#(
  parameter int unsigned SETTLE_UNIT = SETTLE_BASE_CYCLES
)(
  input  wire  logic          aclk,
  input  wire  logic          aresetn,
  input  wire  logic [31:0]   s_axi_awaddr,
  input  wire  logic          s_axi_awvalid,
  output logic                s_axi_awready,
  input  wire  logic [31:0]   s_axi_wdata,
  input  wire  logic [3:0]    s_axi_wstrb,
  input  wire  logic          s_axi_wvalid,
  output logic                s_axi_wready,
  output logic [1:0]          s_axi_bresp,
  output logic                s_axi_bvalid,
  input  wire  logic          s_axi_bready,
  input  wire  logic [31:0]   s_axi_araddr,
  input  wire  logic          s_axi_arvalid,
  output logic                s_axi_arready,
  output logic [31:0]         s_axi_rdata,
  output logic [1:0]          s_axi_rresp,
  output logic                s_axi_rvalid,
  input  wire  logic          s_axi_rready,
  input  wire  logic          sleep_exec,
  input  wire  logic          interrupt_mask,
  input  wire  logic [13:0]   irq_event,
  input  wire  logic          subclock_tick,
  input  wire  logic          word_access,
  input  wire  logic [15:0]   cpu_addr,
  input  wire  logic [7:0]    ccr_in,
  input  wire  logic [15:0]   stacked_word,
  output logic [15:0]         mem_addr,
  output logic [15:0]         ccr_push_word,
  output logic [7:0]          ccr_restore,
  output logic                exception_req,
  output logic [3:0]          exception_src,
  output gate_t               gate,
  output mode_t               mode_out
);

  mode_t       mode_q, mode_d, target_q, target_d;
  logic [7:0]  ctrl1_q, ctrl1_d, ctrl2_q, ctrl2_d, tma_q, tma_d;
  logic [13:0] ien_q, ien_d, irr_q, irr_d;
  logic [11:0] settle_q, settle_d;
  logic        dt_pend_q, dt_pend_d;
  logic        awr_q, awr_d, wr_q, wr_d, bv_q, bv_d, arr_q, arr_d, rv_q, rv_d;
  logic [31:0] awaddr_q, awaddr_d, wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0]  wstrb_q, wstrb_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic        exc_q, exc_d;
  logic [3:0]  src_q, src_d;
  gate_t       gate_q, gate_d;
  logic [15:0] maddr_q, maddr_d, push_q, push_d;
  logic [7:0]  ccrr_q, ccrr_d;

  logic        have_aw, have_w, do_write;
  logic [13:0] valid_mask, pending, clear_bits;
  logic        standby_select_bit, low_speed_on_bit, tbsel, direct_transfer_on_bit;
  logic [2:0]  sts;

  assign standby_select_bit  = ctrl1_q[STANDBY_SELECT_POS];
  assign low_speed_on_bit  = ctrl1_q[LOW_SPEED_ON_POS];
  assign sts   = ctrl1_q[SETTLE_SEL_LSB +: 3];
  assign direct_transfer_on_bit  = ctrl2_q[DIRECT_XFER_POS];
  assign tbsel = tma_q[TIMEBASE_SEL_POS];

  always_comb
  begin
    case (mode_q)
      mode_sleep:     valid_mask = VALID_SLEEP;
      mode_standby:   valid_mask = VALID_STANDBY;
      mode_watch:     valid_mask = VALID_WATCH;
      mode_subactive: valid_mask = VALID_SUBACTIVE;
      mode_settle:    valid_mask = 14'h0000;
      default:        valid_mask = VALID_ACTIVE;
    endcase
  end

  // axi4-lite write/read channels
  assign have_aw  = awr_q == 1'b0;
  assign have_w   = wr_q == 1'b0;
  always_comb
  begin
    awr_d    = awr_q;
    wr_d     = wr_q;
    bv_d     = bv_q;
    bresp_d  = bresp_q;
    awaddr_d = awaddr_q;
    wdata_d  = wdata_q;
    wstrb_d  = wstrb_q;
    do_write = 1'b0;
    if (s_axi_awvalid && awr_q)
    begin
      awaddr_d = s_axi_awaddr;
      awr_d    = 1'b0;
    end
    if (s_axi_wvalid && wr_q)
    begin
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
      wr_d    = 1'b0;
    end
    if (have_aw && have_w && !bv_q)
    begin
      do_write = 1'b1;
      bv_d     = 1'b1;
      if (awaddr_q[7:0] <= ADDR_INT_REQUEST && awaddr_q[31:8] == 24'h0)
        bresp_d = RESP_OKAY;
      else
        bresp_d = RESP_SLVERR;
    end
    if (bv_q && s_axi_bready)
    begin
      bv_d  = 1'b0;
      awr_d = 1'b1;
      wr_d  = 1'b1;
    end
  end

  always_comb
  begin
    arr_d   = arr_q;
    rv_d    = rv_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_arvalid && arr_q)
    begin
      arr_d   = 1'b0;
      rv_d    = 1'b1;
      rresp_d = RESP_OKAY;
      rdata_d = 32'h0000_0000;
      if (s_axi_araddr[31:8] != 24'h0)
        rresp_d = RESP_SLVERR;
      else if (s_axi_araddr[7:0] == ADDR_SYS_CTRL_ONE)
        rdata_d = {24'h0, ctrl1_q};
      else if (s_axi_araddr[7:0] == ADDR_SYS_CTRL_TWO)
        rdata_d = {24'h0, ctrl2_q};
      else if (s_axi_araddr[7:0] == ADDR_TIMER_A_MODE)
        rdata_d = {24'h0, tma_q};
      else if (s_axi_araddr[7:0] == ADDR_INT_ENABLE)
        rdata_d = {18'h0, ien_q};
      else if (s_axi_araddr[7:0] == ADDR_INT_REQUEST)
        rdata_d = {18'h0, irr_q};
      else if (s_axi_araddr[7:0] == ADDR_MODE_STATUS)
        rdata_d = {29'h0, mode_q};
      else
        rresp_d = RESP_SLVERR;
    end
    if (rv_q && s_axi_rready)
    begin
      rv_d  = 1'b0;
      arr_d = 1'b1;
    end
  end

  // registers, mode sequencing and wake gating
  always_comb
  begin
    ctrl1_d    = ctrl1_q;
    ctrl2_d    = ctrl2_q;
    tma_d      = tma_q;
    ien_d      = ien_q;
    clear_bits = 14'h0000;
    if (do_write && wstrb_q[0])
    begin
      if (awaddr_q[7:0] == ADDR_SYS_CTRL_ONE)
        ctrl1_d = wdata_q[7:0];
      else if (awaddr_q[7:0] == ADDR_SYS_CTRL_TWO)
        ctrl2_d = wdata_q[7:0];
      else if (awaddr_q[7:0] == ADDR_TIMER_A_MODE)
        tma_d = wdata_q[7:0];
      else if (awaddr_q[7:0] == ADDR_INT_ENABLE)
        ien_d[7:0] = wdata_q[7:0];
      else if (awaddr_q[7:0] == ADDR_INT_REQUEST)
        clear_bits[7:0] = ~wdata_q[7:0];
    end
    if (do_write && wstrb_q[1])
    begin
      if (awaddr_q[7:0] == ADDR_INT_ENABLE)
        ien_d[13:8] = wdata_q[13:8];
      else if (awaddr_q[7:0] == ADDR_INT_REQUEST)
        clear_bits[13:8] = ~wdata_q[13:8];
    end
    // flags clear by writing zero; a new event wins over the clear
    irr_d = (irr_q & ~clear_bits) | (irq_event & valid_mask);
    dt_pend_d = dt_pend_q;
    if (dt_pend_q && subclock_tick)
    begin
      irr_d[SRC_DIRECT] = 1'b1;
      dt_pend_d = 1'b0;
    end
    pending = irr_q & ien_q & valid_mask;
    // direct flag is raised by the hand-over itself, so it must wake watch
    // and still be taken as an exception once active
    if (mode_q == mode_watch || mode_q == mode_active)
      pending[SRC_DIRECT] = irr_q[SRC_DIRECT] & ien_q[SRC_DIRECT];
    mode_d   = mode_q;
    target_d = target_q;
    settle_d = settle_q;
    exc_d    = 1'b0;
    src_d    = src_q;
    case (mode_q)
      mode_active, mode_subactive:
      begin
        if (!interrupt_mask && pending != 14'h0000)
        begin
          exc_d = 1'b1;
          for (int i = NUM_SRC - 1; i >= 0; i--)
            if (pending[i])
              src_d = 4'(i);
        end
        if (sleep_exec && mode_q == mode_active)
        begin
          if (!standby_select_bit)
            mode_d = mode_sleep;
          else if (!tbsel)
            mode_d = mode_standby;
          else
            mode_d = mode_watch;
        end
        else if (sleep_exec)
        begin
          mode_d = mode_watch;
          if (direct_transfer_on_bit && !low_speed_on_bit)
            dt_pend_d = 1'b1;
        end
      end
      mode_sleep:
        if (!interrupt_mask && pending != 14'h0000)
          mode_d = mode_active;
      mode_standby, mode_watch:
        if (!interrupt_mask && pending != 14'h0000)
        begin
          if (mode_q == mode_watch && low_speed_on_bit && !pending[SRC_DIRECT])
            mode_d = mode_subactive;
          else
          begin
            mode_d   = mode_settle;
            target_d = mode_active;
            settle_d = 12'((32'(sts) + 32'd1) * SETTLE_UNIT);
          end
        end
      default:
        if (settle_q <= 12'd1)
          mode_d = target_q;
        else
          settle_d = settle_q - 12'd1;
    endcase
    // gating outputs per mode
    gate_d = '0;
    case (mode_d)
      mode_active: gate_d.timer_a_run = 1'b1;
      mode_sleep:
      begin
        gate_d.cpu_halt     = 1'b1;
        gate_d.periph_halt  = 1'b1;
        gate_d.timer_a_run  = 1'b1;
        gate_d.output_reset = 1'b1;
      end
      mode_subactive:
      begin
        gate_d.clock_stop      = 1'b1;
        gate_d.cpu_on_subclock = 1'b1;
        gate_d.periph_halt     = 1'b1;
        gate_d.timer_a_run     = tbsel;
        gate_d.output_reset    = 1'b1;
        gate_d.ports_hiz       = 1'b1;
        gate_d.hv_pmos_off     = 1'b1;
      end
      default:
      begin
        gate_d.clock_stop   = 1'b1;
        gate_d.cpu_halt     = 1'b1;
        gate_d.periph_halt  = 1'b1;
        gate_d.timer_a_run  = (mode_d == mode_watch) && tbsel;
        gate_d.output_reset = 1'b1;
        gate_d.ports_hiz    = 1'b1;
        gate_d.hv_pmos_off  = 1'b1;
      end
    endcase
    // stack word helpers; software keeps the pointer even anyway
    maddr_d = word_access ? {cpu_addr[15:1], 1'b0} : cpu_addr;
    push_d  = {ccr_in, ccr_in};
    ccrr_d  = stacked_word[15:8];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_q    <= mode_active;
      target_q  <= mode_active;
      ctrl1_q   <= SYS_CTRL_ONE_RST;
      ctrl2_q   <= SYS_CTRL_TWO_RST;
      tma_q     <= TIMER_A_MODE_RST;
      ien_q     <= INT_ENABLE_RST;
      irr_q     <= 14'h0000;
      settle_q  <= 12'h000;
      dt_pend_q <= 1'b0;
      awr_q     <= 1'b1;
      wr_q      <= 1'b1;
      bv_q      <= 1'b0;
      arr_q     <= 1'b1;
      rv_q      <= 1'b0;
      awaddr_q  <= 32'h0000_0000;
      wdata_q   <= 32'h0000_0000;
      rdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bresp_q   <= RESP_OKAY;
      rresp_q   <= RESP_OKAY;
      exc_q     <= 1'b0;
      src_q     <= 4'h0;
      gate_q    <= '0;
      maddr_q   <= 16'h0000;
      push_q    <= 16'h0000;
      ccrr_q    <= 8'h00;
    end
    else
    begin
      mode_q    <= mode_d;
      target_q  <= target_d;
      ctrl1_q   <= ctrl1_d;
      ctrl2_q   <= ctrl2_d;
      tma_q     <= tma_d;
      ien_q     <= ien_d;
      irr_q     <= irr_d;
      settle_q  <= settle_d;
      dt_pend_q <= dt_pend_d;
      awr_q     <= awr_d;
      wr_q      <= wr_d;
      bv_q      <= bv_d;
      arr_q     <= arr_d;
      rv_q      <= rv_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      rdata_q   <= rdata_d;
      wstrb_q   <= wstrb_d;
      bresp_q   <= bresp_d;
      rresp_q   <= rresp_d;
      exc_q     <= exc_d;
      src_q     <= src_d;
      gate_q    <= gate_d;
      maddr_q   <= maddr_d;
      push_q    <= push_d;
      ccrr_q    <= ccrr_d;
    end
  end

  assign s_axi_awready = awr_q;
  assign s_axi_wready  = wr_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arr_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign exception_req = exc_q;
  assign exception_src = src_q;
  assign gate          = gate_q;
  assign mode_out      = mode_q;
  assign mem_addr      = maddr_q;
  assign ccr_push_word = push_q;
  assign ccr_restore   = ccrr_q;

endmodule : power_mode_controller

// ### verification/power_mode_controller_monitor.sv
// checker: mode gating, exception gating and cpu word-path helpers
// assumes it is bound onto power_mode_controller and sees its ports only
`timescale 1ns/1ps
module power_mode_controller_monitor
  import power_mode_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        sleep_exec,
  input wire logic        interrupt_mask,
  input wire logic        word_access,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0]  ccr_in,
  input wire logic [15:0] stacked_word,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] ccr_push_word,
  input wire logic [7:0]  ccr_restore,
  input wire logic        exception_req,
  input gate_t            gate,
  input mode_t            mode_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire low_q = mode_out inside {mode_sleep, mode_standby, mode_watch,
                                mode_subactive};
  sequence s_sleep_taken;
    mode_out == mode_active && sleep_exec;
  endsequence
  sequence s_low_entry;
    mode_out inside {mode_sleep, mode_standby, mode_watch};
  endsequence
  a_sleep_entry: assert property (s_sleep_taken |=> s_low_entry)
    else $error("sleep entry missed");
  // gated on sampled reset: the release edge itself still loads zeros
  a_word_even: assert property (aresetn && word_access |=>
    mem_addr == {$past(cpu_addr[15:1]), 1'b0})
    else $error("word address not even");
  a_ccr_both: assert property (aresetn |=>
    ccr_push_word == {$past(ccr_in), $past(ccr_in)})
    else $error("pushed ccr word wrong");
  a_ccr_even: assert property (aresetn |=>
    ccr_restore == $past(stacked_word[15:8]))
    else $error("restored ccr not even byte");
  a_active_gates: assert property (mode_out == mode_active |->
    !gate.cpu_halt && !gate.clock_stop && !gate.periph_halt)
    else $error("active mode gated");
  a_low_outrst: assert property (low_q |-> gate.output_reset)
    else $error("outputs not reset in low power");
  a_standby_gates: assert property (mode_out == mode_standby |->
    gate.clock_stop && gate.ports_hiz && gate.hv_pmos_off && gate.cpu_halt)
    else $error("standby gating wrong");
  a_sleep_gates: assert property (mode_out == mode_sleep |->
    !gate.clock_stop && gate.cpu_halt && gate.timer_a_run)
    else $error("sleep gating wrong");
  a_sub_clock: assert property (mode_out == mode_subactive |->
    gate.cpu_on_subclock && !gate.cpu_halt)
    else $error("subactive cpu not on subclock");
  // rise only: a level that pends into sleep entry is not a new exception
  a_exc_mode: assert property ($rose(exception_req) |->
    mode_out inside {mode_active, mode_subactive})
    else $error("exception raised in halted mode");
  a_exc_mask: assert property ($rose(exception_req) |->
    !$past(interrupt_mask))
    else $error("exception raised while masked");
  a_reset_active: assert property (disable iff (1'b0)
    !aresetn |=> mode_out == mode_active && !exception_req)
    else $error("reset left a low power mode");
endmodule : power_mode_controller_monitor

bind power_mode_controller power_mode_controller_monitor u_mon (
  .aclk(aclk), .aresetn(aresetn), .sleep_exec(sleep_exec),
  .interrupt_mask(interrupt_mask), .word_access(word_access),
  .cpu_addr(cpu_addr), .ccr_in(ccr_in), .stacked_word(stacked_word),
  .mem_addr(mem_addr), .ccr_push_word(ccr_push_word),
  .ccr_restore(ccr_restore), .exception_req(exception_req),
  .gate(gate), .mode_out(mode_out)
);

// ### verification/cpu_core_model.sv
// cpu core and interrupt source model facing the power mode controller
// assumes one aclk; all outputs change by nba just after a rising edge
`timescale 1ns/1ps
module cpu_core_model
  import power_mode_pkg::*;
(
  input wire logic aclk,
  output logic        sleep_exec,
  output logic        interrupt_mask,
  output logic [13:0] irq_event,
  output logic        subclock_tick,
  output logic        word_access,
  output logic [15:0] cpu_addr,
  output logic [7:0]  ccr_in,
  output logic [15:0] stacked_word
);
  logic [2:0] div_q;
  initial
  begin
    {sleep_exec, irq_event, subclock_tick, word_access} = '0;
    {cpu_addr, ccr_in, stacked_word, div_q} = '0;
    interrupt_mask = 1'b1;
  end
  // subclock runs in every mode, so the tick is free running
  always @(posedge aclk)
  begin
    div_q <= div_q + 3'h1;
    subclock_tick <= (div_q == 3'h7);
  end
  task do_sleep();
    @(posedge aclk) sleep_exec <= 1'b1;
    @(posedge aclk) sleep_exec <= 1'b0;
  endtask : do_sleep
  task pulse(input int unsigned idx);
    @(posedge aclk) irq_event[idx] <= 1'b1;
    @(posedge aclk) irq_event <= '0;
  endtask : pulse
  task set_mask(input logic m);
    @(posedge aclk) interrupt_mask <= m;
  endtask : set_mask
  task access(input logic w, input logic [15:0] a);
    @(posedge aclk) word_access <= w;
    cpu_addr <= a;
  endtask : access
  task stack_op(input logic [15:0] sp, input logic [7:0] c,
                input logic [15:0] s);
    @(posedge aclk) word_access <= 1'b1;
    cpu_addr <= {sp[15:1], 1'b0};
    ccr_in <= c;
    stacked_word <= s;
  endtask : stack_op
endmodule : cpu_core_model

// ### verification/test_power_mode_controller.sv
// testbench: register access, mode sequencing and cpu word paths
// assumes axi4-lite master tasks here and cpu_core_model as far side
`timescale 1ns/1ps
module test_power_mode_controller
  import power_mode_pkg::*;
;
  localparam int unsigned SU = 2;
  logic        aclk, aresetn;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, exception_src;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, exception_req;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        sleep_exec, interrupt_mask, subclock_tick, word_access;
  logic [13:0] irq_event;
  logic [15:0] cpu_addr, stacked_word, mem_addr, ccr_push_word;
  logic [7:0]  ccr_in, ccr_restore;
  gate_t       gate;
  mode_t       mode_out;
  int          n_errors, checks;

  power_mode_controller #(.SETTLE_UNIT(SU)) DUT (.*);
  cpu_core_model u_cpu (.*);

  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    r = 2'b11;
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    for (int i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    check("bresp", r, er);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
    logic [1:0] r;
    logic [31:0] d;
    {r, d} = '1;
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    for (int i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
      begin
        r = s_axi_rresp;
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    check("rresp", r, er);
    check("rdata", d, ex);
  endtask : rd
  // sample a step after the edge so the mode register has landed
  task wm(input mode_t m);
    #1;
    for (int i = 0; i < 300 && mode_out !== m; i++)
    begin
      @(posedge aclk);
      #1;
    end
    check("mode", mode_out, m);
  endtask : wm
  task settle(input int unsigned n);
    int c;
    c = 0;
    while (mode_out === mode_settle && c < 200)
    begin
      @(posedge aclk);
      #1;
      c++;
    end
    check("settle", c, n);
    check("mode", mode_out, mode_active);
  endtask : settle
  task exc(input logic [3:0] src);
    @(posedge aclk);
    #1;
    check("exc_req", exception_req, 1'b1);
    check("exc_src", exception_src, src);
    wr(ADDR_INT_REQUEST, 32'h0, RESP_OKAY);
  endtask : exc
  task close_out();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  initial
  begin
    #400000;
    n_errors++;
    close_out();
  end

  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_wdata} = '0;
    s_axi_araddr = '0;
    s_axi_wstrb = 4'hf;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_SYS_CTRL_ONE, {24'h0, SYS_CTRL_ONE_RST}, RESP_OKAY);
    rd(ADDR_INT_ENABLE, {18'h0, INT_ENABLE_RST}, RESP_OKAY);
    wr(ADDR_INT_ENABLE, 32'h0000_0423, RESP_OKAY);
    rd(ADDR_INT_ENABLE, 32'h0000_0423, RESP_OKAY);
    wr(ADDR_MODE_STATUS, 32'h1, RESP_SLVERR);
    rd(8'h40, 32'h0, RESP_SLVERR);
    $display("test registers done");
    wr(ADDR_SYS_CTRL_ONE, 32'h0, RESP_OKAY);
    u_cpu.do_sleep();
    wm(mode_sleep);
    u_cpu.pulse(SRC_EXT4);
    rd(ADDR_INT_REQUEST, 32'h0, RESP_OKAY);
    u_cpu.pulse(SRC_EXT1);
    repeat (3) @(posedge aclk);
    wm(mode_sleep);
    u_cpu.set_mask(1'b0);
    wm(mode_active);
    exc(4'(SRC_EXT1));
    $display("test sleep done");
    wr(ADDR_SYS_CTRL_ONE, 32'h90, RESP_OKAY);
    u_cpu.do_sleep();
    wm(mode_standby);
    u_cpu.pulse(SRC_EXT0);
    wm(mode_settle);
    settle(2 * SU);
    exc(4'(SRC_EXT0));
    $display("test standby done");
    wr(ADDR_TIMER_A_MODE, 32'h08, RESP_OKAY);
    wr(ADDR_SYS_CTRL_ONE, 32'h88, RESP_OKAY);
    u_cpu.do_sleep();
    wm(mode_watch);
    check("ta_run", gate.timer_a_run, 1'b1);
    u_cpu.pulse(SRC_EXT1);
    rd(ADDR_INT_REQUEST, 32'h0, RESP_OKAY);
    wm(mode_watch);
    u_cpu.pulse(SRC_TIMER_A);
    wm(mode_subactive);
    check("ta_run", gate.timer_a_run, 1'b1);
    exc(4'(SRC_TIMER_A));
    u_cpu.do_sleep();
    wm(mode_watch);
    wr(ADDR_SYS_CTRL_ONE, 32'h80, RESP_OKAY);
    u_cpu.pulse(SRC_EXT0);
    wm(mode_settle);
    settle(SU);
    exc(4'(SRC_EXT0));
    $display("test watch done");
    wr(ADDR_SYS_CTRL_ONE, 32'h88, RESP_OKAY);
    u_cpu.do_sleep();
    wm(mode_watch);
    u_cpu.pulse(SRC_EXT0);
    wm(mode_subactive);
    wr(ADDR_INT_REQUEST, 32'h0, RESP_OKAY);
    wr(ADDR_SYS_CTRL_TWO, 32'h1, RESP_OKAY);
    wr(ADDR_SYS_CTRL_ONE, 32'h80, RESP_OKAY);
    u_cpu.do_sleep();
    wm(mode_watch);
    wm(mode_settle);
    settle(SU);
    exc(4'(SRC_DIRECT));
    wr(ADDR_SYS_CTRL_TWO, 32'h0, RESP_OKAY);
    $display("test direct transfer done");
    u_cpu.access(1'b1, 16'h1235);
    @(posedge aclk);
    #1 check("mem_addr", mem_addr, 16'h1234);
    u_cpu.access(1'b0, 16'h1235);
    @(posedge aclk);
    #1 check("mem_addr", mem_addr, 16'h1235);
    u_cpu.stack_op(16'h0ff0, 8'h5a, 16'ha53c);
    @(posedge aclk);
    #1 check("ccr_push", ccr_push_word, 16'h5a5a);
    check("ccr_restore", ccr_restore, 8'ha5);
    $display("test cpu paths done");
    wr(ADDR_SYS_CTRL_ONE, 32'h0, RESP_OKAY);
    u_cpu.do_sleep();
    wm(mode_sleep);
    @(posedge aclk) aresetn <= 1'b0;
    @(posedge aclk) aresetn <= 1'b1;
    #1 check("mode", mode_out, mode_active);
    rd(ADDR_INT_ENABLE, {18'h0, INT_ENABLE_RST}, RESP_OKAY);
    $display("test reset done");
    close_out();
  end
endmodule : test_power_mode_controller
